/* File: dv/tb_wall_clock.sv */
// Purpose : Self-checking bench for the seconds clock block
// Assumes : One AHB-Lite master, single slave, shortened second counts
// Notes   : Every scenario task judges its own results
`timescale 1ns/1ns
module tb_wall_clock;
   import wall_clock_pkg::*;
   // ----------
   // Setup
   // ----------
   localparam int FAST = 50;
   localparam int SLOW = 10;  // Keeps the 5:1 ratio of the two sources
   localparam logic [31:0] RUN = 32'h00008000;
   localparam logic [31:0] HLT = 32'h00004000;
   localparam logic [31:0] AIE = 32'h00002000;
   localparam logic [31:0] TIE = 32'h00001000;
   localparam logic [31:0] SEL = 32'h00000800;
   localparam logic [31:0] FA  = 32'h00000200;
   localparam logic [31:0] F1  = 32'h00000100;

   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'b010;
   logic [31:0] hwdata = 32'h00000000;
   logic        debugFreeze = 1'b0;
   wire  [31:0] hrdata;
   wire         hreadyout;
   wire         hresp;
   wire         irq;
   wire  [7:0]  irqPriorityLevel;
   logic [31:0] rd;
   int          err_count = 0;
   int          comparisons = 0;
   int          cyc = 0;
   int          t0;
   int          t1;

   wall_clock #(.FAST_CYC(FAST), .SLOW_CYC(SLOW)) uut (
      .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .debugFreeze(debugFreeze), .irq(irq), .irqPriorityLevel(irqPriorityLevel));

   always #5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   // ----------
   // Helpers
   // ----------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task chk_span(input int got, input int lo, input int hi);
      comparisons++;
      if (got < lo || got > hi) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask : chk_span

   // Hready is sampled before the edge's own updates land
   task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= wr;
      do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 100);
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
      do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 100);
      rd = hrdata;
      hwrite <= 1'b0;
      if (n >= 100) chk(n, 0);
   endtask : bus

   task wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task rd_chk(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h00000000);
      chk(rd, exp);
   endtask : rd_chk

   task wait_irq(input int lim, output int at);
      int n;
      n = 0;
      do begin @(posedge clk); n++; end while (irq !== 1'b1 && n < lim);
      at = cyc;
      if (n >= lim) chk(n, 0);
   endtask : wait_irq

   // ----------
   // Scenarios
   // ----------
   task t_reset;
      chk({31'h0, irq}, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      rd_chk(OFF_STATUS_CTRL, 32'h0);
      rd_chk(OFF_COUNT, COUNT_RESET);
      rd_chk(OFF_ALARM, ALARM_RESET);
      rd_chk(OFF_KEY, 32'h0);
      wr(12'h010, 32'h12345678);
      rd_chk(12'h010, 32'h0);
      $display("test reset done");
   endtask : t_reset

   task t_lock;
      wr(OFF_COUNT, 32'h5);
      rd_chk(OFF_COUNT, 32'h0);
      wr(OFF_KEY, UNLOCK_KEY);
      rd_chk(OFF_KEY, 32'h1);
      wr(OFF_COUNT, 32'h5);
      rd_chk(OFF_COUNT, 32'h5);
      wr(OFF_KEY, 32'h1);
      wr(OFF_COUNT, 32'h9);
      rd_chk(OFF_COUNT, 32'h5);
      wr(OFF_KEY, UNLOCK_KEY);
      $display("test lock done");
   endtask : t_lock

   task t_prio;
      wr(OFF_STATUS_CTRL, 32'h000004a5);
      chk({24'h0, irqPriorityLevel}, 32'ha5);
      rd_chk(OFF_STATUS_CTRL, 32'h000000a5);
      wr(OFF_STATUS_CTRL, 32'h0);
      $display("test priority done");
   endtask : t_prio

   // Interval between two flag raises is the whole second
   task t_period(input logic [31:0] sel, input int per);
      wr(OFF_STATUS_CTRL, RUN | TIE | sel | F1);
      wait_irq(3 * per, t0);
      wr(OFF_STATUS_CTRL, RUN | TIE | sel | F1);
      chk({31'h0, irq}, 32'h0);
      wait_irq(3 * per, t1);
      chk_span(t1 - t0, per, per);
      wr(OFF_STATUS_CTRL, F1);
      $display("test period done");
   endtask : t_period

   task t_stop;
      wr(OFF_COUNT, 32'h10);
      repeat (2 * FAST) @(posedge clk);
      rd_chk(OFF_COUNT, 32'h10);
      $display("test stop done");
   endtask : t_stop

   task t_freeze;
      @(posedge clk) debugFreeze <= 1'b1;
      wr(OFF_STATUS_CTRL, RUN | HLT);
      wr(OFF_COUNT, 32'h20);
      repeat (2 * FAST) @(posedge clk);
      rd_chk(OFF_COUNT, 32'h20);
      @(posedge clk) debugFreeze <= 1'b0;
      repeat (FAST + 10) @(posedge clk);
      rd_chk(OFF_COUNT, 32'h21);
      @(posedge clk) debugFreeze <= 1'b1;
      wr(OFF_STATUS_CTRL, RUN);
      wr(OFF_COUNT, 32'h30);
      repeat (FAST + 10) @(posedge clk);
      rd_chk(OFF_COUNT, 32'h31);
      @(posedge clk) debugFreeze <= 1'b0;
      wr(OFF_STATUS_CTRL, F1);
      $display("test freeze done");
   endtask : t_freeze

   // Mid-second count write must push the next tick a full second out
   task t_restart;
      wr(OFF_STATUS_CTRL, RUN | TIE | F1);
      wait_irq(3 * FAST, t0);
      wr(OFF_STATUS_CTRL, RUN | TIE | F1);
      repeat (20) @(posedge clk);
      wr(OFF_COUNT, 32'h40);
      t0 = cyc;
      wait_irq(3 * FAST, t1);
      chk_span(t1 - t0, FAST - 4, FAST + 2);
      rd_chk(OFF_COUNT, 32'h41);
      wr(OFF_STATUS_CTRL, F1);
      $display("test restart done");
   endtask : t_restart

   task t_alarm;
      wr(OFF_COUNT, 32'h100);
      wr(OFF_ALARM, 32'h102);
      wr(OFF_STATUS_CTRL, RUN | AIE | F1 | FA);
      wait_irq(3 * FAST + 20, t0);
      rd_chk(OFF_COUNT, 32'h102);
      rd_chk(OFF_STATUS_CTRL, RUN | AIE | FA | F1);
      wr(OFF_STATUS_CTRL, RUN | AIE | FA);
      chk({31'h0, irq}, 32'h0);
      rd_chk(OFF_STATUS_CTRL, RUN | AIE | F1);
      wr(OFF_STATUS_CTRL, F1);
      $display("test alarm done");
   endtask : t_alarm

   // ----------
   // Closing
   // ----------
   task give_verdict;
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict

   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_lock();
      t_prio();
      t_period(32'h0, FAST);
      t_period(SEL, SLOW);
      t_stop();
      t_freeze();
      t_restart();
      t_alarm();
      give_verdict();
   end

   // Tests need about 1000 cycles; twenty times that means a hang
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      give_verdict();
   end
endmodule : tb_wall_clock

/* File: logic/second_prescaler.sv */
// Purpose : Divides clk down to one tick per second
// Assumes : clk is the selected source, limits set by the parent
// Notes   : Restart clears the count and suppresses that cycle's tick
`timescale 1ns/1ns
module second_prescaler #(
   parameter int FAST_CYC = wall_clock_pkg::SECOND_FAST_CYC,
   parameter int SLOW_CYC = wall_clock_pkg::SECOND_SLOW_CYC
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic run,
   input  wire logic restart,
   input  wire logic slowSel,
   output logic      tick
);
   import wall_clock_pkg::*;

   logic [PRESC_W-1:0] cnt_r;
   logic [PRESC_W-1:0] cnt_nxt;
   logic               tick_r;
   logic               tick_nxt;
   logic [PRESC_W-1:0] lastCnt;

   // ----------------------------------------
   // Divider
   // ----------------------------------------
   always_comb begin
      lastCnt  = slowSel ? PRESC_W'(SLOW_CYC - 1) : PRESC_W'(FAST_CYC - 1);
      cnt_nxt  = cnt_r;
      tick_nxt = 1'b0;
      if (restart) begin
         cnt_nxt = '0;
      end else if (run) begin
         // Compare with >= so a switch to the slow source never overshoots
         if (cnt_r >= lastCnt) begin
            cnt_nxt  = '0;
            tick_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + PRESC_W'(1);
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r  <= '0;
         tick_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_restart_clears: assert property (restart |=> cnt_r == '0 && !tick_r)
      else $error("prescaler not cleared by restart");
   a_tick_at_limit: assert property (tick_r |-> $past(cnt_r) >= $past(lastCnt) && $past(run))
      else $error("tick not at selected limit");
   a_idle_no_tick: assert property (!run |=> !tick_r && $stable(cnt_r) || $past(restart))
      else $error("prescaler moved while stopped");

endmodule : second_prescaler

/* File: logic/wall_clock.sv */
// Purpose : Seconds counter with alarm, per-second flag and write lock
// Assumes : AHB-Lite master, single word transfers, one slave
// Notes   : Every transfer takes one wait state; response always OKAY
//
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ns
module wall_clock #(
   parameter int FAST_CYC = wall_clock_pkg::SECOND_FAST_CYC,
   parameter int SLOW_CYC = wall_clock_pkg::SECOND_SLOW_CYC
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        debugFreeze,
   output logic             irq,
   output logic      [7:0]  irqPriorityLevel
);
   import wall_clock_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   bus_state_e   busState_r;
   bus_state_e   busState_nxt;
   logic [11:0]  addr_r;
   logic [11:0]  addr_nxt;
   logic         write_r;
   logic         write_nxt;
   logic [31:0]  rdata_r;
   logic [31:0]  rdata_nxt;
   logic         readyOut_r;
   logic         readyOut_nxt;
   logic         resp_r;

   status_ctrl_s ctrl_r;
   status_ctrl_s ctrl_nxt;
   logic [31:0]  count_r;
   logic [31:0]  count_nxt;
   logic [31:0]  alarm_r;
   logic [31:0]  alarm_nxt;
   logic         unlocked_r;
   logic         unlocked_nxt;
   logic         matchSeen_r;
   logic         matchSeen_nxt;
   logic         irq_r;
   logic         irq_nxt;
   logic [7:0]   prio_r;

   logic         freezeMeta_r;
   logic         freezeSync_r;
   logic         addrPhase;
   logic         dataWrite;
   logic         ctrlWrite;
   logic         countWrite;
   logic         countTry;
   logic         alarmWrite;
   logic         keyWrite;
   logic         running;
   logic         tick;
   logic         matchNow;
   logic         mapped;

   // ----------------------------------------
   // Debug freeze synchroniser
   // ----------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         freezeMeta_r <= 1'b0;
         freezeSync_r <= 1'b0;
      end else begin
         freezeMeta_r <= debugFreeze;
         freezeSync_r <= freezeMeta_r;
      end
   end

   // ----------------------------------------
   // AHB-Lite slave
   // ----------------------------------------
   assign addrPhase  = hsel && htrans[1] && hready;
   assign dataWrite  = (busState_r == BUS_WAIT) && write_r;
   assign mapped     = (addr_r[11:4] == 8'h00);
   assign ctrlWrite  = dataWrite && addr_r == OFF_STATUS_CTRL;
   assign countTry   = dataWrite && addr_r == OFF_COUNT;
   assign countWrite = countTry && unlocked_r;
   assign alarmWrite = dataWrite && addr_r == OFF_ALARM;
   assign keyWrite   = dataWrite && addr_r == OFF_KEY;

   always_comb begin
      busState_nxt = busState_r;
      addr_nxt     = addr_r;
      write_nxt    = write_r;
      rdata_nxt    = rdata_r;
      readyOut_nxt = readyOut_r;
      case (busState_r)
         BUS_IDLE, BUS_RESP: begin
            if (addrPhase) begin
               busState_nxt = BUS_WAIT;
               addr_nxt     = {haddr[11:2], 2'b00};
               write_nxt    = hwrite;
               readyOut_nxt = 1'b0;
            end else begin
               busState_nxt = BUS_IDLE;
               readyOut_nxt = 1'b1;
            end
         end
         BUS_WAIT: begin
            // Wait state lets read data leave a flop
            busState_nxt = BUS_RESP;
            readyOut_nxt = 1'b1;
            rdata_nxt    = 32'h00000000;
            if (!write_r && mapped) begin
               case (addr_r[3:2])
                  2'b00:   rdata_nxt = {16'h0000, ctrl_r};
                  2'b01:   rdata_nxt = count_r;
                  2'b10:   rdata_nxt = alarm_r;
                  default: rdata_nxt = {31'h00000000, unlocked_r};
               endcase
            end
         end
         default: begin
            busState_nxt = BUS_IDLE;
            readyOut_nxt = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         busState_r <= BUS_IDLE;
         addr_r     <= 12'h000;
         write_r    <= 1'b0;
         rdata_r    <= 32'h00000000;
         readyOut_r <= 1'b1;
         resp_r     <= 1'b0;
      end else begin
         busState_r <= busState_nxt;
         addr_r     <= addr_nxt;
         write_r    <= write_nxt;
         rdata_r    <= rdata_nxt;
         readyOut_r <= readyOut_nxt;
         resp_r     <= 1'b0;
      end
   end

   // ----------------------------------------
   // Seconds divider
   // ----------------------------------------
   assign running = ctrl_r.counterRun && !(ctrl_r.haltInDebug && freezeSync_r);

   second_prescaler #(
      .FAST_CYC (FAST_CYC),
      .SLOW_CYC (SLOW_CYC)
   ) u_prescaler (
      .clk     (clk),
      .sys_rst (sys_rst),
      .run     (running),
      .restart (countWrite),
      .slowSel (ctrl_r.slowSourceSelect),
      .tick    (tick)
   );

   // ----------------------------------------
   // Counter, alarm, flags and lock
   // ----------------------------------------
   assign matchNow = (count_r == alarm_r);

   always_comb begin
      ctrl_nxt      = ctrl_r;
      count_nxt     = count_r;
      alarm_nxt     = alarm_r;
      unlocked_nxt  = unlocked_r;
      matchSeen_nxt = matchNow;
      if (ctrlWrite) begin
         ctrl_nxt.counterRun       = hwdata[15];
         ctrl_nxt.haltInDebug      = hwdata[14];
         ctrl_nxt.alarmIrqEnable   = hwdata[13];
         ctrl_nxt.perTickIrqEnable = hwdata[12];
         ctrl_nxt.slowSourceSelect = hwdata[11];
         ctrl_nxt.irqPriorityLevel = hwdata[7:0];
         if (hwdata[POS_ONE_HZ_FLAG]) begin
            ctrl_nxt.oneHzFlag = 1'b0;
         end
         if (hwdata[POS_ALARM_FLAG]) begin
            ctrl_nxt.alarmMatchFlag = 1'b0;
         end
      end
      // Sets come after clears so a same-cycle event is kept
      if (tick) begin
         ctrl_nxt.oneHzFlag = 1'b1;
      end
      if (matchNow && !matchSeen_r) begin
         ctrl_nxt.alarmMatchFlag = 1'b1;
      end
      ctrl_nxt.reserved = 1'b0;
      if (countWrite) begin
         count_nxt = hwdata;
      end else if (tick) begin
         count_nxt = count_r + 32'h00000001;
      end
      if (alarmWrite) begin
         alarm_nxt = hwdata;
      end
      if (keyWrite) begin
         unlocked_nxt = (hwdata == UNLOCK_KEY);
      end
      irq_nxt = (ctrl_nxt.oneHzFlag && ctrl_nxt.perTickIrqEnable)
             || (ctrl_nxt.alarmMatchFlag && ctrl_nxt.alarmIrqEnable);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_r      <= CTRL_RESET;
         count_r     <= COUNT_RESET;
         alarm_r     <= ALARM_RESET;
         unlocked_r  <= 1'b0;
         matchSeen_r <= 1'b1;
         irq_r       <= 1'b0;
         prio_r      <= 8'h00;
      end else begin
         ctrl_r      <= ctrl_nxt;
         count_r     <= count_nxt;
         alarm_r     <= alarm_nxt;
         unlocked_r  <= unlocked_nxt;
         matchSeen_r <= matchSeen_nxt;
         irq_r       <= irq_nxt;
         prio_r      <= ctrl_nxt.irqPriorityLevel;
      end
   end

   assign hrdata           = rdata_r;
   assign hreadyout        = readyOut_r;
   assign hresp            = resp_r;
   assign irq              = irq_r;
   assign irqPriorityLevel = prio_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_count_only_moves: assert property ($changed(count_r) |-> $past(tick) || $past(countWrite))
      else $error("count changed without tick or write");
   a_tick_increments: assert property (tick && !countWrite |=> count_r == $past(count_r) + 32'h00000001)
      else $error("count did not advance on tick");
   a_freeze_stops: assert property (ctrl_r.haltInDebug && freezeSync_r |=> !tick)
      else $error("second advanced while frozen");
   a_stop_no_tick: assert property (!ctrl_r.counterRun |=> !tick)
      else $error("second advanced while stopped");
   a_tick_sets_flag: assert property (tick |=> ctrl_r.oneHzFlag)
      else $error("per-second flag not set");
   a_alarm_sets: assert property (matchNow && !matchSeen_r |=> ctrl_r.alarmMatchFlag)
      else $error("alarm flag not set on match");
   a_irq_tick: assert property (ctrl_r.oneHzFlag && ctrl_r.perTickIrqEnable |-> irq)
      else $error("per-second interrupt missing");
   a_irq_alarm: assert property (ctrl_r.alarmMatchFlag && ctrl_r.alarmIrqEnable |-> irq)
      else $error("alarm interrupt missing");
   a_irq_drops: assert property (!(ctrl_r.oneHzFlag && ctrl_r.perTickIrqEnable)
      && !(ctrl_r.alarmMatchFlag && ctrl_r.alarmIrqEnable) |-> !irq)
      else $error("interrupt without enabled flag");
   a_prio_level: assert property (irqPriorityLevel == ctrl_r.irqPriorityLevel)
      else $error("priority output differs from field");
   a_locked_write: assert property (countTry && !unlocked_r && !tick |=> $stable(count_r))
      else $error("locked count was written");
   a_count_write: assert property (countWrite |=> count_r == $past(hwdata))
      else $error("count write not stored");
   a_wait_state: assert property (addrPhase |=> !hreadyout ##1 hreadyout)
      else $error("bus timing broken");
   a_resp_okay: assert property (!hresp)
      else $error("error response driven");
   a_key_unlock: assert property (keyWrite |=> unlocked_r == ($past(hwdata) == UNLOCK_KEY))
      else $error("lock state not set by key write");
   a_flag_clear: assert property (ctrlWrite && hwdata[POS_ONE_HZ_FLAG] && !tick |=> !ctrl_r.oneHzFlag)
      else $error("per-second flag not cleared");

   c_tick_seen: cover property (tick ##1 irq);
   c_alarm_hit: cover property (matchNow && !matchSeen_r ##1 ctrl_r.alarmMatchFlag);
   c_unlock_write: cover property (keyWrite ##[1:20] countWrite);
   c_frozen: cover property (ctrl_r.haltInDebug && freezeSync_r && ctrl_r.counterRun);

endmodule : wall_clock

/* File: logic/wall_clock_pkg.sv */
// Purpose : Shared constants and types for the seconds clock block
// Assumes : AHB-Lite slave, 32-bit data, word accesses only
// Notes   : Prescaler limits are overridable at the top for simulation
package wall_clock_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [11:0] OFF_STATUS_CTRL = 12'h000;
   localparam logic [11:0] OFF_COUNT       = 12'h004;
   localparam logic [11:0] OFF_ALARM       = 12'h008;
   localparam logic [11:0] OFF_KEY         = 12'h00c;

   localparam logic [31:0] UNLOCK_KEY      = 32'h55ccaa33;
   localparam logic [15:0] CTRL_RESET      = 16'h0000;
   localparam logic [31:0] COUNT_RESET     = 32'h00000000;
   localparam logic [31:0] ALARM_RESET     = 32'hffffffff;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int POS_ONE_HZ_FLAG = 8;
   localparam int POS_ALARM_FLAG  = 9;

   // ----------------------------------------
   // Seconds timing
   // ----------------------------------------
   localparam int SRC_FAST_MHZ    = 20;
   localparam int SRC_SLOW_MHZ    = 4;
   localparam int CYCLES_PER_MHZ  = 1000000;
   localparam int SECOND_FAST_CYC = SRC_FAST_MHZ * CYCLES_PER_MHZ;
   localparam int SECOND_SLOW_CYC = SRC_SLOW_MHZ * CYCLES_PER_MHZ;
   localparam int PRESC_W         = 25;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic       counterRun;
      logic       haltInDebug;
      logic       alarmIrqEnable;
      logic       perTickIrqEnable;
      logic       slowSourceSelect;
      logic       reserved;
      logic       alarmMatchFlag;
      logic       oneHzFlag;
      logic [7:0] irqPriorityLevel;
   } status_ctrl_s;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_WAIT = 2'b01,
      BUS_RESP = 2'b11
   } bus_state_e;

endpackage : wall_clock_pkg
